// ---- pkg/atg_pkg.sv ----
// Constants and types shared by the strobe timing generator files.
// Assumes a single 250 MHz ref_clk and a synchronous, active-high reset.
`default_nettype none

package atg_pkg;

  // Clock rates; the strobe phases are counted in 60 MHz periods.
  localparam int REF_CLK_MHZ = 250;
  localparam int XFER_CLK_MHZ = 60;
  localparam logic [7:0] TICK_INC = 8'(XFER_CLK_MHZ);
  localparam logic [7:0] TICK_WRAP = 8'(REF_CLK_MHZ);
  localparam logic [7:0] TICK_ACC_RST = 8'h00;

  // Programmed counts are 5 bits; phase lengths with overhead need 6.
  localparam int CNT_W = 5;
  localparam int LEN_W = 6;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;

  // Fixed overhead added to each programmed count, in 60 MHz periods.
  localparam logic [LEN_W-1:0] PIO_HOLD_TICKS = 6'h02;
  localparam logic [LEN_W-1:0] PIO_ASSERT_EXTRA = 6'h01;
  localparam logic [LEN_W-1:0] PIO_RECOV_EXTRA = PIO_HOLD_TICKS;
  localparam logic [LEN_W-1:0] MW_ASSERT_EXTRA = 6'h01;
  localparam logic [LEN_W-1:0] MW_RECOV_EXTRA = 6'h02;
  localparam logic [LEN_W-1:0] ULTRA_DMA_MODE_ASSERT_EXTRA = 6'h02;
  localparam logic [LEN_W-1:0] ULTRA_DMA_MODE_RECOV_EXTRA = 6'h01;

  // Data path.
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int LEVEL_W = 6;

  // AXI4-Lite register map (byte addresses).
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_PIO_ASSERT = 8'h00;
  localparam logic [7:0] OFF_PIO_RECOV = 8'h04;
  localparam logic [7:0] OFF_DMA_ASSERT = 8'h08;
  localparam logic [7:0] OFF_DMA_RECOV = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_DATA = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Field positions.
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_EN_BIT = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_STATE_LSB = 1;
  localparam int STAT_TYPE_LSB = 4;
  localparam int STAT_PAUSE = 6;
  localparam int STAT_STROBE = 7;
  localparam int STAT_LEVEL_LSB = 8;
  localparam logic [1:0] CTRL_TYPE_RST = 2'h0;

  typedef enum logic [1:0] {
    XFER_PIO,
    XFER_MULTIWORD_DMA,
    XFER_ULTRA_DMA
  } atg_xfer_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ASSERT,
    ST_RECOVER,
    ST_ULTRA_DMA_MODE_RECOVER,
    ST_ULTRA_DMA_MODE_WAIT
  } atg_state_t;

endpackage

`default_nettype wire

// ---- pkg/atg_stream_if.sv ----
// Valid/ready word stream between the generator and its FIFO.
// Assumes both ends run on the same clock.
`default_nettype none

interface atg_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- hdl/atg_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`default_nettype none

module atg_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic flush,
  // Stream sides
  atg_stream_if.snk wr,
  atg_stream_if.src rd,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] level_q;
  logic push;
  logic pop;

  assign wr.ready = level_q != (AW+1)'(DEPTH);
  assign rd.valid = level_q != '0;
  assign rd.data = mem[rdPtr_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;
  assign level = level_q;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= wr.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      level_q <= level_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // atg_fifo

`default_nettype wire

// ---- hdl/atg_phase_timer.sv ----
// Down counter that times one strobe phase in 60 MHz periods.
// Assumes load and tick come from logic on the same clock.
`default_nettype none

module atg_phase_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic abort,
  // Timing
  input wire logic tick,
  input wire logic load,
  input wire logic [atg_pkg::LEN_W-1:0] loadLen,
  output logic expire
);
  import atg_pkg::*;

  logic [LEN_W-1:0] cnt_q;

  // The phase ends on the tick that takes the count from one to zero.
  assign expire = tick && (cnt_q == LEN_W'(1));

  always_ff @(posedge ref_clk) begin
    if (srst || abort) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= loadLen;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule // atg_phase_timer

`default_nettype wire

// ---- hdl/atg_strobe_timing.sv ----
// Strobe timing generator: AXI4-Lite registers, a word FIFO and the
// phase state machine that drives the drive-side write strobe.
// Assumes a 250 MHz ref_clk and a drive pause pin from outside.
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Contract
// - Phases counted in 60 MHz periods.
// - PIO/multiword: assert +1, recover +2.
// - Ultra DMA: assert +2, recover +1.
// - Ultra DMA recovery may stretch 1-3 cycles; the code's wait after recovery has no upper limit.
// - Ultra DMA recovery only when burst pauses; the code also recovers when the FIFO runs empty or the engine is disabled.
// - Ultra DMA cycle is two assertion intervals.
// - Counts are 5 bits, upper bits zero.
// - Counts clear on reset, survive bus reset.
// - PIO write hold is two recovery cycles.
module atg_strobe_timing (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Host-side bus reset; stops the engine, keeps timing counts
  input wire logic hostBusRst,
  // AXI4-Lite write address and data
  input wire logic [atg_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [atg_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive side
  output logic ataStrobe,
  output logic [atg_pkg::DATA_W-1:0] ataDataOut,
  output logic ataDataOe,
  input wire logic udmaPause
);
  import atg_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [7:0] tickAcc_q;
  logic [8:0] accSum;
  logic tick;

  logic pauseMeta_q;
  logic pauseSync_q;

  logic awHeld_q;
  logic [AXI_AW-1:0] awAddr_q;
  logic wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [AXI_AW-1:0] wrAddr;
  logic [AXI_AW-1:0] rdAddr;
  logic wrIsData;
  logic wrMapped;
  logic wrGo;
  logic [31:0] rdWord;
  logic rdMapped;
  logic [31:0] statusWord;

  logic [CNT_W-1:0] pioAssertCount_q;
  logic [CNT_W-1:0] pioRecoveryCount_q;
  logic [CNT_W-1:0] dmaAssertCount_q;
  logic [CNT_W-1:0] dmaRecoveryCount_q;
  logic [1:0] xferType_q;
  logic xferEnable_q;

  atg_state_t state_q;
  atg_state_t state_d;
  atg_xfer_t activeType_q;
  atg_xfer_t reqType;
  atg_xfer_t selType;
  logic strobe_q;
  logic [DATA_W-1:0] dataOut_q;
  logic dataOe_q;
  logic [LEN_W-1:0] assertLen;
  logic [LEN_W-1:0] recovLen;
  logic [LEN_W-1:0] loadLen;
  logic load;
  logic pop;
  logic expire;
  logic canGo;
  logic [LEVEL_W-1:0] fifoLevel;

  atg_stream_if #(.W(DATA_W)) pushIf ();
  atg_stream_if #(.W(DATA_W)) popIf ();

  ////////////////////////////////////////////////////////////////////
  // Transfer clock enable and pause synchroniser.

  assign accSum = {1'b0, tickAcc_q} + {1'b0, TICK_INC};
  assign tick = accSum >= {1'b0, TICK_WRAP};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tickAcc_q <= TICK_ACC_RST;
    end else if (tick) begin
      tickAcc_q <= 8'(accSum - {1'b0, TICK_WRAP});
    end else begin
      tickAcc_q <= accSum[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pauseMeta_q <= 1'b0;
      pauseSync_q <= 1'b0;
    end else begin
      pauseMeta_q <= udmaPause;
      pauseSync_q <= pauseMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.

  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wrAddr = {awAddr_q[AXI_AW-1:2], 2'b00};
  assign wrIsData = wrAddr == OFF_DATA;
  assign wrMapped = wrAddr == OFF_PIO_ASSERT || wrAddr == OFF_PIO_RECOV
    || wrAddr == OFF_DMA_ASSERT || wrAddr == OFF_DMA_RECOV
    || wrAddr == OFF_CTRL || wrAddr == OFF_STATUS || wrIsData;

  // A data write waits for FIFO space before it is answered.
  assign pushIf.valid = awHeld_q && wHeld_q && !bvalid_q && wrIsData;
  assign pushIf.data = wData_q[DATA_W-1:0];
  assign wrGo = awHeld_q && wHeld_q && !bvalid_q && (!wrIsData || pushIf.ready);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrGo) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrGo) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wrGo) begin
      bvalid_q <= 1'b1;
      bresp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Timing and control registers.

  // Cleared only by srst, never by hostBusRst.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pioAssertCount_q <= CNT_RST;
      pioRecoveryCount_q <= CNT_RST;
      dmaAssertCount_q <= CNT_RST;
      dmaRecoveryCount_q <= CNT_RST;
      xferType_q <= CTRL_TYPE_RST;
      xferEnable_q <= 1'b0;
    end else if (wrGo && wStrb_q[0]) begin
      case (wrAddr)
        OFF_PIO_ASSERT: pioAssertCount_q <= wData_q[CNT_W-1:0];
        OFF_PIO_RECOV: pioRecoveryCount_q <= wData_q[CNT_W-1:0];
        OFF_DMA_ASSERT: dmaAssertCount_q <= wData_q[CNT_W-1:0];
        OFF_DMA_RECOV: dmaRecoveryCount_q <= wData_q[CNT_W-1:0];
        OFF_CTRL: begin
          xferType_q <= wData_q[CTRL_TYPE_LSB +: 2];
          xferEnable_q <= wData_q[CTRL_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rdAddr = {s_axi_araddr[AXI_AW-1:2], 2'b00};

  always_comb begin
    statusWord = '0;
    statusWord[STAT_BUSY] = state_q != ST_IDLE;
    statusWord[STAT_STATE_LSB +: 3] = state_q;
    statusWord[STAT_TYPE_LSB +: 2] = activeType_q;
    statusWord[STAT_PAUSE] = pauseSync_q;
    statusWord[STAT_STROBE] = strobe_q;
    statusWord[STAT_LEVEL_LSB +: LEVEL_W] = fifoLevel;
  end

  always_comb begin
    rdWord = '0;
    rdMapped = 1'b1;
    case (rdAddr)
      OFF_PIO_ASSERT: rdWord[CNT_W-1:0] = pioAssertCount_q;
      OFF_PIO_RECOV: rdWord[CNT_W-1:0] = pioRecoveryCount_q;
      OFF_DMA_ASSERT: rdWord[CNT_W-1:0] = dmaAssertCount_q;
      OFF_DMA_RECOV: rdWord[CNT_W-1:0] = dmaRecoveryCount_q;
      OFF_CTRL: begin
        rdWord[CTRL_TYPE_LSB +: 2] = xferType_q;
        rdWord[CTRL_EN_BIT] = xferEnable_q;
      end
      OFF_STATUS: rdWord = statusWord;
      OFF_DATA: rdWord = '0;
      default: rdMapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdWord;
      rresp_q <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Word buffer and phase timer.

  atg_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .flush(hostBusRst),
    .wr(pushIf),
    .rd(popIf),
    .level(fifoLevel)
  );

  atg_phase_timer timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .abort(hostBusRst),
    .tick(tick),
    .load(load),
    .loadLen(loadLen),
    .expire(expire)
  );

  ////////////////////////////////////////////////////////////////////
  // Phase lengths.

  // Undefined type codes fall back to PIO.
  assign reqType = xferType_q == 2'h3 ? XFER_PIO : atg_xfer_t'(xferType_q);
  // Idle uses the requested type, else the latched one.
  assign selType = state_q == ST_IDLE ? reqType : activeType_q;

  always_comb begin
    case (selType)
      XFER_ULTRA_DMA: begin
        assertLen = {1'b0, dmaAssertCount_q} + ULTRA_DMA_MODE_ASSERT_EXTRA;
        recovLen = {1'b0, dmaRecoveryCount_q} + ULTRA_DMA_MODE_RECOV_EXTRA;
      end
      XFER_MULTIWORD_DMA: begin
        assertLen = {1'b0, dmaAssertCount_q} + MW_ASSERT_EXTRA;
        recovLen = {1'b0, dmaRecoveryCount_q} + MW_RECOV_EXTRA;
      end
      default: begin
        assertLen = {1'b0, pioAssertCount_q} + PIO_ASSERT_EXTRA;
        recovLen = {1'b0, pioRecoveryCount_q} + PIO_RECOV_EXTRA;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Phase state machine. Strobe edges fall on a tick, except the drop when a disable ends the ultra DMA wait.

  assign canGo = xferEnable_q && popIf.valid;
  assign popIf.ready = pop;

  always_comb begin
    state_d = state_q;
    load = 1'b0;
    loadLen = assertLen;
    pop = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (tick && canGo) begin
          pop = 1'b1;
          load = 1'b1;
          state_d = ST_ASSERT;
        end
      end
      ST_ASSERT: begin
        if (expire) begin
          load = 1'b1;
          if (activeType_q != XFER_ULTRA_DMA) begin
            loadLen = recovLen;
            state_d = ST_RECOVER;
          end else if (canGo && !pauseSync_q) begin
            pop = 1'b1;
          end else begin
            loadLen = recovLen;
            state_d = ST_ULTRA_DMA_MODE_RECOVER;
          end
        end
      end
      ST_RECOVER: begin
        if (expire) begin
          if (canGo) begin
            pop = 1'b1;
            load = 1'b1;
            state_d = ST_ASSERT;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_ULTRA_DMA_MODE_RECOVER: begin
        if (expire) begin
          state_d = ST_ULTRA_DMA_MODE_WAIT;
        end
      end
      ST_ULTRA_DMA_MODE_WAIT: begin
        // Resume waits for a tick, a FIFO word, the enable and a clear synchronised pause.
        if (tick && canGo && !pauseSync_q) begin
          pop = 1'b1;
          load = 1'b1;
          state_d = ST_ASSERT;
        end else if (!xferEnable_q) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst || hostBusRst) begin
      state_q <= ST_IDLE;
      activeType_q <= XFER_PIO;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && pop) begin
        activeType_q <= reqType;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || hostBusRst) begin
      strobe_q <= 1'b0;
      dataOut_q <= '0;
      dataOe_q <= 1'b0;
    end else begin
      if (pop) begin
        dataOut_q <= popIf.data;
        dataOe_q <= 1'b1;
        // Ultra DMA moves a word on each strobe edge.
        strobe_q <= selType == XFER_ULTRA_DMA ? !strobe_q : 1'b1;
      end else if (state_d == ST_IDLE) begin
        strobe_q <= 1'b0;
        dataOe_q <= 1'b0;
      end else if (state_d == ST_RECOVER) begin
        strobe_q <= 1'b0;
      end
    end
  end

  assign ataStrobe = strobe_q;
  assign ataDataOut = dataOut_q;
  assign ataDataOe = dataOe_q;

endmodule // atg_strobe_timing

`default_nettype wire

// ---- tb/atg_strobe_timing_asserts.sv ----
// Port checker for the strobe timing generator, bound to its top.
// Assumes one ref_clk domain and synchronous active-high resets.
`default_nettype none
module atg_strobe_timing_asserts (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hostBusRst,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive side
  input wire logic ataStrobe,
  input wire logic [atg_pkg::DATA_W-1:0] ataDataOut,
  input wire logic ataDataOe
);
  timeunit 1ns;
  timeprecision 1ps;
  import atg_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response withdrawn");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data withdrawn");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_aw_held;
    $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
  endproperty
  a_aw_held: assert property (p_aw_held) else $error("write answered before taken");
  property p_oe;
    disable iff (srst || hostBusRst) ataStrobe |-> ataDataOe;
  endproperty
  a_oe: assert property (p_oe) else $error("strobe without data");
  property p_data_hold;
    disable iff (srst || hostBusRst)
    ataDataOe && $past(ataDataOe) && $stable(ataStrobe) |-> $stable(ataDataOut);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved mid phase");
  property p_high_min;
    disable iff (srst || hostBusRst) $rose(ataStrobe) |-> ataStrobe [*4];
  endproperty
  a_high_min: assert property (p_high_min) else $error("strobe high too short");
  property p_low_min;
    disable iff (srst || hostBusRst) $fell(ataStrobe) |-> !ataStrobe [*8];
  endproperty
  a_low_min: assert property (p_low_min) else $error("strobe low too short");
  c_strobe: cover property ($rose(ataStrobe));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // atg_strobe_timing_asserts

bind atg_strobe_timing atg_strobe_timing_asserts i_atg_strobe_timing_asserts (
  .ref_clk, .srst, .hostBusRst, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .ataStrobe, .ataDataOut, .ataDataOe
);
`default_nettype wire

// ---- tb/atg_drive_model.sv ----
// Drive-side model: times strobe phases and captures written words.
// Assumes strobe, data and enable are registered on ref_clk.
`default_nettype none
module atg_drive_model (
  // Clock
  input wire logic ref_clk,
  // Drive pins
  input wire logic ataStrobe,
  input wire logic ataDataOe,
  input wire logic [15:0] ataDataOut,
  output logic udmaPause,
  // Bench control
  input wire logic pauseReq,
  input wire logic bothEdges
);
  timeunit 1ns;
  timeprecision 1ps;
  int runs[$];
  logic [15:0] words[$];
  int run = 0;
  logic last = 1'h0;
  logic oeAll = 1'h0;
  ////////////////////////////////////////
  // The drive pauses a burst only when the bench asks.
  assign udmaPause = pauseReq;
  // Phase runs are rounded to 60 MHz periods; idle gaps are skipped.
  always @(posedge ref_clk) begin
    if (ataStrobe !== last) begin
      if (oeAll) runs.push_back((run * 60 + 125) / 250);
      if (ataDataOe && (ataStrobe || bothEdges)) words.push_back(ataDataOut);
      run = 1;
      last = ataStrobe;
      oeAll = ataDataOe;
    end else begin
      run++;
      oeAll = oeAll && ataDataOe;
    end
  end
endmodule // atg_drive_model
`default_nettype wire

// ---- tb/atg_strobe_timing_tb.sv ----
// Bench for the strobe timing generator: registers, FIFO and phases.
// Assumes the drive model and the bound checker are compiled with it.
`default_nettype none
module atg_strobe_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import atg_pkg::*;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic hostBusRst = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic pauseReq = 1'h0;
  logic bothEdges = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ataStrobe, ataDataOe, udmaPause;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, t;
  logic [31:0] s_axi_rdata, rdv;
  logic [15:0] ataDataOut;
  int mismatches = 0;
  int check_count = 0;
  int n, i, k, mx, cnt, e0, e1;
  logic [1:0] cTyp [3] = '{2'h3, 2'h1, 2'h2};
  int cAs [3] = '{4, 4, 2};
  int cRc [3] = '{1, 2, 5};

  atg_strobe_timing i_atg_strobe_timing (
    .ref_clk, .srst, .hostBusRst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ataStrobe,
    .ataDataOut, .ataDataOe, .udmaPause
  );
  atg_drive_model i_atg_drive_model (
    .ref_clk, .ataStrobe, .ataDataOe, .ataDataOut, .udmaPause, .pauseReq, .bothEdges
  );
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic bound(input int used, input int lim);
    if (used >= lim) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 400; n++) begin
      @(posedge ref_clk);
      if (aw && w && s_axi_bvalid) break;
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'h0;
      end
    end
    rsp = s_axi_bresp;
    bound(n, 400);
  endtask
  task automatic rd(input logic [7:0] a);
    bit ar;
    ar = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 400; n++) begin
      @(posedge ref_clk);
      if (ar && s_axi_rvalid) break;
      if (!ar && s_axi_arready) begin
        ar = 1'b1;
        s_axi_arvalid <= 1'h0;
      end
    end
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    bound(n, 400);
  endtask
  // Waits for the word count at the drive and an idle or parked ultra DMA engine.
  task automatic wait_idle(input int cntWords);
    int j;
    for (j = 0; j < 4000; j++) begin
      rd(OFF_STATUS);
      if ((rdv[STAT_BUSY] === 1'b0 || rdv[STAT_STATE_LSB +: 3] === 3'h4)
          && i_atg_drive_model.words.size() >= cntWords) break;
    end
    bound(j, 4000);
  endtask
  task automatic clear_model();
    i_atg_drive_model.runs.delete();
    i_atg_drive_model.words.delete();
  endtask
  ////////////////////////////////////////
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'h0;
    for (i = 0; i < 5; i++) begin
      rd(8'(4 * i));
      chk(rdv, 32'h0); // cleared
    end
    wr(OFF_PIO_RECOV, 32'hFFFF_FFFF);
    rd(OFF_PIO_RECOV);
    chk(rdv, 32'h1F); // field width
    wr(8'h1C, 32'h1);
    chk(rsp, RESP_SLVERR);
    rd(8'h1C);
    chk(rsp, RESP_SLVERR);
    chk(rdv, 32'h0);
    wr(OFF_STATUS, 32'hFF);
    chk(rsp, RESP_OKAY);
    rd(OFF_STATUS);
    chk(rdv, 32'h0);
    for (i = 0; i < 3; i++) begin
      t = cTyp[i];
      wr((t == 2'h1 || t == 2'h2) ? OFF_DMA_ASSERT : OFF_PIO_ASSERT, 32'(cAs[i]));
      wr((t == 2'h1 || t == 2'h2) ? OFF_DMA_RECOV : OFF_PIO_RECOV, 32'(cRc[i]));
      wr(OFF_CTRL, {30'h0, t});
      bothEdges <= (t == 2'h2);
      clear_model();
      for (k = 0; k < 3; k++) wr(OFF_DATA, 32'hA000 + 32'(16 * i + k));
      chk(i_atg_drive_model.words.size(), 32'h0); // held while off
      wr(OFF_CTRL, {29'h0, 1'h1, t});
      wait_idle(3);
      e0 = (t == 2'h2) ? cAs[i] + 2 : cAs[i] + 1;
      e1 = (t == 2'h2) ? cAs[i] + 2 : cRc[i] + 2;
      chk(i_atg_drive_model.runs[0], e0); // assertion
      chk(i_atg_drive_model.runs[1], e1); // second phase
      for (k = 0; k < 3; k++) chk(i_atg_drive_model.words[k], 32'hA000 + 32'(16 * i + k));
    end
    wr(OFF_CTRL, 32'h2);
    wr(OFF_DMA_RECOV, 32'h14);
    clear_model();
    for (k = 0; k < 6; k++) wr(OFF_DATA, 32'hB000 + 32'(k));
    wr(OFF_CTRL, 32'h6);
    for (k = 0; k < 400 && i_atg_drive_model.words.size() < 2; k++) @(posedge ref_clk);
    bound(k, 400);
    pauseReq <= 1'h1;
    repeat (24) @(posedge ref_clk);
    pauseReq <= 1'h0;
    wait_idle(6);
    mx = 0;
    cnt = 0;
    for (k = 0; k < i_atg_drive_model.runs.size(); k++) begin
      if (i_atg_drive_model.runs[k] > mx) mx = i_atg_drive_model.runs[k];
      if (i_atg_drive_model.runs[k] == 4) cnt++;
    end
    chk(mx >= 21 && mx <= 30, 32'h1); // recovery gap
    chk(cnt >= 4, 32'h1); // unpaused cycles
    for (k = 0; k < 6; k++) chk(i_atg_drive_model.words[k], 32'hB000 + 32'(k)); // words
    bothEdges <= 1'h0;
    wr(OFF_CTRL, 32'h0); // end parked burst
    wr(OFF_PIO_ASSERT, 32'h11);
    wr(OFF_PIO_RECOV, 32'h10);
    clear_model();
    wr(OFF_CTRL, 32'h4);
    for (k = 0; k < 33; k++) wr(OFF_DATA, 32'h1000 + 32'(k));
    rd(OFF_STATUS);
    chk(rdv[STAT_LEVEL_LSB +: LEVEL_W], 32'h20);
    wr(OFF_DATA, 32'h1021);
    chk(n > 8, 32'h1);
    wr(OFF_CTRL, 32'h5);
    wait_idle(34);
    chk(i_atg_drive_model.runs.size(), 32'h43);
    for (k = 0; k < i_atg_drive_model.runs.size(); k++) begin
      chk(i_atg_drive_model.runs[k], 32'h12); // kept type
    end
    for (k = 0; k < 34; k++) chk(i_atg_drive_model.words[k], 32'h1000 + 32'(k));
    hostBusRst <= 1'h1;
    @(posedge ref_clk);
    hostBusRst <= 1'h0;
    rd(OFF_PIO_ASSERT);
    chk(rdv, 32'h11); // kept on bus reset
    end_of_test();
  end
endmodule // atg_strobe_timing_tb
`default_nettype wire
